// File: sha_pkg.sv
`default_nettype none
package sha_pkg;
	// Register offsets on the plain register port
	localparam logic [2:0] REG_CMD = 3'h0;
	localparam logic [2:0] REG_DATA = 3'h1;
	localparam logic [2:0] REG_STAT = 3'h2;
	localparam logic [2:0] REG_INTR = 3'h3;

	// Status register bit positions
	localparam int ST_INVALID = 0;
	localparam int ST_EXT_MODE = 1;
	localparam int ST_REPLY_RDY = 2;
	localparam int ST_IDLE_RDY = 4;
	localparam int ST_TEST_FAIL = 6;
	localparam int ST_TEST_RUN = 7;
	// Interrupt register bit positions
	localparam int IR_COMPLETE = 2;
	localparam int IR_PENDING = 7;

	// Opcodes
	localparam logic [7:0] OP_MBOX24 = 8'h01;
	localparam logic [7:0] OP_INQ_SETUP = 8'h0d;
	localparam logic [7:0] OP_WR_FIFO = 8'h10;
	localparam logic [7:0] OP_WR_RAM = 8'h1a;
	localparam logic [7:0] OP_RD_RAM = 8'h1b;
	localparam logic [7:0] OP_RD_FIFO = 8'h1d;
	localparam logic [7:0] OP_ECHO = 8'h1f;
	localparam logic [7:0] OP_DIAG = 8'h20;
	localparam logic [7:0] OP_OPTIONS = 8'h21;
	localparam logic [7:0] OP_MBOX32 = 8'h81;
	localparam logic [7:0] OP_INQ_EXT = 8'h8d;

	// Transfer lengths in bytes
	localparam logic [6:0] RAM_LEN = 7'd64;
	localparam logic [6:0] FIFO_LEN = 7'd54;
	// Reply sizes
	localparam logic [7:0] INQ_BYTES = 8'd17;
	localparam logic [7:0] EXT_BYTES = 8'd4;

	// Self-test duration
	localparam int CLK_PERIOD_NS = 50;
	localparam int DIAG_TIME_NS = 100000;
	localparam int DIAG_CYCLES = (DIAG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Reset values
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] MBOX_COUNT_RESET = 8'h00;

	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_PARAM = 6'b000010,
		S_EXEC = 6'b000100,
		S_REPLY = 6'b001000,
		S_DMA = 6'b010000,
		S_DIAG = 6'b100000
	} sha_state_t;
endpackage
`default_nettype wire

// File: sha_cmd.sv
// Our own choices: the strobed register port and the address map.
`default_nettype none
module sha_cmd #(
	parameter int DIAG_LEN = sha_pkg::DIAG_CYCLES,
	parameter logic [7:0] BUS_TYPE = 8'h45,
	parameter logic [7:0] BIOS_CODE = 8'h00,
	// Arbitrary neutral default
	parameter logic [15:0] SG_MAX = 16'h0080
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [2:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	input wire logic [7:0] tgt_present,
	input wire logic [2:0] own_id,
	input wire logic [7:0] sync_agreed,
	input wire logic [23:0] sync_period,
	input wire logic [31:0] sync_offset,
	input wire logic cfg_sync_neg,
	input wire logic cfg_parity,
	input wire logic [7:0] diag_fail_count,
	output logic dma_req,
	output logic dma_to_host,
	output logic [23:0] dma_addr,
	output logic [6:0] dma_len,
	input wire logic dma_done,
	input wire logic dma_ok,
	output logic adapter_hard_reset,
	output logic [7:0] disconnect_mask,
	output logic [7:0] busy_retry_mask,
	output logic [7:0] mbox_count,
	output logic [31:0] mbox_base,
	output logic mbox_ext
);
	import sha_pkg::*;

	// The self-test counter is 16 bits wide, so longer runs cannot be timed
	if (DIAG_LEN < 2 || DIAG_LEN > 65536) begin : g_chk
		$error("DIAG_LEN must lie between 2 and 65536");
	end

	function automatic logic [8:0] param_count(input logic [7:0] op);
		unique case (op)
			OP_MBOX24: param_count = 9'd4;
			OP_INQ_SETUP, OP_ECHO, OP_OPTIONS, OP_INQ_EXT: param_count = 9'd1;
			OP_WR_RAM, OP_RD_RAM, OP_WR_FIFO, OP_RD_FIFO: param_count = 9'd3;
			OP_MBOX32: param_count = 9'd5;
			default: param_count = 9'd0;
		endcase
	endfunction

	function automatic logic [7:0] sync_byte(input logic present, input logic is_own, input logic agreed,
		input logic [2:0] period, input logic [3:0] offset);
		sync_byte = (present && !is_own) ? {agreed, period, offset} : 8'h00;
	endfunction

	logic rst_ff1, rst_n;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_ff1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_ff1 <= 1'b1;
			rst_n <= rst_ff1;
		end
	end

	sha_state_t state;
	logic [7:0] opcode, pcnt, ridx, rlen, data_in;
	logic [8:0] pneed;
	logic [7:0] prm [0:4];
	logic reply_rdy, complete, pending, invalid, test_run, test_fail, idle_rdy;
	logic [15:0] diag_cnt;

	wire wr_cmd = bus_wr && bus_addr == REG_CMD;
	wire rd_data = bus_rd && bus_addr == REG_DATA;
	wire clr_intr = bus_wr && bus_addr == REG_INTR;
	wire st_exec = state == S_EXEC;
	wire st_reply = state == S_REPLY;
	wire is_dma = opcode == OP_WR_RAM || opcode == OP_RD_RAM || opcode == OP_WR_FIFO || opcode == OP_RD_FIFO;
	wire is_reply = opcode == OP_ECHO || opcode == OP_INQ_SETUP || opcode == OP_INQ_EXT;
	// The length byte of the options command redefines how many bytes follow
	wire first_opt = opcode == OP_OPTIONS && pcnt == 8'h00;
	wire last_param = first_opt ? bus_wdata == 8'h00 : {1'b0, pcnt} + 9'd1 == pneed;
	wire mbox_zero = opcode == OP_MBOX32 && prm[0] == 8'h00;
	wire diag_end = state == S_DIAG && diag_cnt == 16'(DIAG_LEN - 1);
	wire diag_bad = diag_fail_count != 8'h00;
	wire reply_load = st_reply && !reply_rdy && ridx != rlen;
	wire fin_exec = st_exec && !is_dma && !is_reply && opcode != OP_DIAG;
	wire fin_reply = st_reply && !reply_rdy && ridx == rlen;
	wire fin_dma = state == S_DMA && dma_done;
	wire finish = fin_exec || fin_reply || fin_dma || diag_end;
	wire cmd_bad = (fin_exec && (param_count(opcode) == 9'd0 && opcode != OP_DIAG || mbox_zero)) ||
		(fin_dma && !dma_ok);

	// Setup inquiry reply image
	logic [7:0] inq [0:16];
	assign inq[0] = {6'h00, cfg_parity, cfg_sync_neg};
	assign inq[1] = 8'h00;
	assign inq[2] = 8'h00;
	assign inq[3] = 8'h00;
	assign inq[4] = mbox_count;
	assign inq[5] = mbox_base[23:16];
	assign inq[6] = mbox_base[15:8];
	assign inq[7] = mbox_base[7:0];
	for (genvar t = 0; t < 8; t++) begin : g_sync
		assign inq[8 + t] = sync_byte(tgt_present[t], own_id == 3'(t), sync_agreed[t],
			sync_period[3 * t +: 3], sync_offset[4 * t +: 4]);
	end
	assign inq[16] = disconnect_mask;

	logic [7:0] ext [0:3];
	assign ext[0] = BUS_TYPE;
	assign ext[1] = BIOS_CODE;
	assign ext[2] = SG_MAX[7:0];
	assign ext[3] = SG_MAX[15:8];

	wire [7:0] inq_sel = ridx < INQ_BYTES ? inq[ridx[4:0]] : 8'h00;
	wire [7:0] ext_sel = ridx < EXT_BYTES ? ext[ridx[1:0]] : 8'h00;
	wire [7:0] reply_byte = opcode == OP_ECHO ? prm[0] : opcode == OP_INQ_SETUP ? inq_sel : ext_sel;

	wire [7:0] stat_word = {test_run, test_fail, 1'b0, idle_rdy, 1'b0, reply_rdy, mbox_ext, invalid};
	wire [7:0] intr_word = {pending, 4'h0, complete, 2'b00};
	wire [7:0] rd_mux = bus_addr == REG_DATA ? data_in : bus_addr == REG_STAT ? stat_word :
		bus_addr == REG_INTR ? intr_word : 8'h00;

	// Hardware sets win over software clears in the same cycle
	wire next_complete = finish || (complete && !(clr_intr && bus_wdata[IR_COMPLETE]));
	wire next_pending = finish || (pending && !(clr_intr && bus_wdata[IR_PENDING]));
	wire next_reply_rdy = reply_load || (diag_end && diag_bad) || (reply_rdy && !rd_data);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata <= 8'h00;
			complete <= 1'b0;
			pending <= 1'b0;
			reply_rdy <= 1'b0;
		end else begin
			bus_rdata <= bus_rd ? rd_mux : 8'h00;
			complete <= next_complete;
			pending <= next_pending;
			reply_rdy <= next_reply_rdy;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			opcode <= 8'h00;
			pcnt <= 8'h00;
			pneed <= 9'd0;
			for (int i = 0; i < 5; i++) begin
				prm[i] <= 8'h00;
			end
		end else begin
			unique case (state)
				S_IDLE: if (wr_cmd) begin
					opcode <= bus_wdata;
					pcnt <= 8'h00;
					pneed <= param_count(bus_wdata);
					state <= param_count(bus_wdata) == 9'd0 ? S_EXEC : S_PARAM;
				end
				S_PARAM: if (wr_cmd) begin
					if (pcnt < 8'd5) begin
						prm[pcnt[2:0]] <= bus_wdata;
					end
					if (first_opt) begin
						pneed <= 9'd1 + {1'b0, bus_wdata};
					end
					pcnt <= pcnt + 8'd1;
					if (last_param) begin
						state <= S_EXEC;
					end
				end
				S_EXEC: state <= is_dma ? S_DMA : is_reply ? S_REPLY : opcode == OP_DIAG ? S_DIAG : S_IDLE;
				S_REPLY: if (fin_reply) begin
					state <= S_IDLE;
				end
				S_DMA: if (dma_done) begin
					state <= S_IDLE;
				end
				S_DIAG: if (diag_end) begin
					state <= S_IDLE;
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ridx <= 8'h00;
			rlen <= 8'h00;
			data_in <= 8'h00;
		end else if (st_exec) begin
			ridx <= 8'h00;
			rlen <= opcode == OP_ECHO ? 8'd1 : prm[0];
		end else if (reply_load) begin
			data_in <= reply_byte;
			ridx <= ridx + 8'd1;
		end else if (diag_end && diag_bad) begin
			data_in <= diag_fail_count;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dma_req <= 1'b0;
			dma_to_host <= 1'b0;
			dma_addr <= 24'h000000;
			dma_len <= 7'd0;
		end else if (st_exec && is_dma) begin
			dma_req <= 1'b1;
			dma_to_host <= opcode == OP_RD_RAM || opcode == OP_RD_FIFO;
			dma_addr <= {prm[0], prm[1], prm[2]};
			dma_len <= opcode == OP_WR_RAM || opcode == OP_RD_RAM ? RAM_LEN : FIFO_LEN;
		end else if (dma_done) begin
			dma_req <= 1'b0;
		end
	end

	// A diagnostic acts as a hard reset, so the options and mailbox setup are lost
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			disconnect_mask <= MASK_RESET;
			busy_retry_mask <= MASK_RESET;
			mbox_count <= MBOX_COUNT_RESET;
			mbox_base <= 32'h00000000;
			mbox_ext <= 1'b0;
		end else if (st_exec && opcode == OP_DIAG) begin
			disconnect_mask <= MASK_RESET;
			busy_retry_mask <= MASK_RESET;
			mbox_count <= MBOX_COUNT_RESET;
			mbox_base <= 32'h00000000;
			mbox_ext <= 1'b0;
		end else if (state == S_PARAM && wr_cmd && opcode == OP_OPTIONS) begin
			if (pcnt == 8'd1) begin
				disconnect_mask <= bus_wdata;
			end
			if (pcnt == 8'd2) begin
				busy_retry_mask <= bus_wdata;
			end
		end else if (st_exec && opcode == OP_MBOX24) begin
			mbox_count <= prm[0];
			mbox_base <= {8'h00, prm[1], prm[2], prm[3]};
			mbox_ext <= 1'b0;
		end else if (st_exec && opcode == OP_MBOX32 && !mbox_zero) begin
			mbox_count <= prm[0];
			mbox_base <= {prm[4], prm[3], prm[2], prm[1]};
			mbox_ext <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			invalid <= 1'b0;
			test_run <= 1'b0;
			test_fail <= 1'b0;
			idle_rdy <= 1'b1;
			diag_cnt <= 16'h0000;
			adapter_hard_reset <= 1'b0;
		end else begin
			adapter_hard_reset <= st_exec && opcode == OP_DIAG;
			diag_cnt <= state == S_DIAG ? diag_cnt + 16'h0001 : 16'h0000;
			if (wr_cmd && state == S_IDLE) begin
				invalid <= 1'b0;
				test_fail <= 1'b0;
				idle_rdy <= 1'b0;
			end else if (finish) begin
				invalid <= cmd_bad;
				idle_rdy <= 1'b1;
			end
			if (st_exec && opcode == OP_DIAG) begin
				test_run <= 1'b1;
			end else if (diag_end) begin
				test_run <= 1'b0;
				test_fail <= diag_bad;
			end
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	own_sync_zero_a: assert property (inq[8 + own_id] == 8'h00) else $error("own target sync byte not zero");
	disc_echo_a: assert property (inq[16] == disconnect_mask) else $error("byte 16 not disconnect mask");
	dma_addr_a: assert property (st_exec && is_dma |=> dma_req && dma_addr == {$past(prm[0]), $past(prm[1]),
		$past(prm[2])}) else $error("dma address not assembled MSB first");
	ram_len_a: assert property (dma_req && (opcode == OP_WR_RAM || opcode == OP_RD_RAM) |-> dma_len == 7'd64)
		else $error("local RAM transfer not 64 bytes");
	fifo_len_a: assert property (dma_req && (opcode == OP_WR_FIFO || opcode == OP_RD_FIFO) |-> dma_len == 7'd54)
		else $error("FIFO transfer not 54 bytes");
	dma_done_a: assert property (dma_req && dma_done |=> complete && !dma_req) else $error("no completion");
	echo_byte_a: assert property (st_reply && opcode == OP_ECHO && reply_rdy |-> data_in == prm[0])
		else $error("echo byte differs");
	echo_done_a: assert property (st_reply && opcode == OP_ECHO && reply_rdy && rd_data && !complete
		|=> !complete ##1 complete) else $error("echo completion timing wrong");
	diag_run_a: assert property (state == S_DIAG |-> test_run) else $error("self-test flag low");
	diag_end_a: assert property (diag_end |=> !test_run && complete && pending && idle_rdy)
		else $error("diagnostic end flags wrong");
	diag_fail_a: assert property (diag_end && diag_bad |=> reply_rdy && data_in == $past(diag_fail_count))
		else $error("failure count not returned");
	diag_pass_a: assert property (diag_end && !diag_bad && !reply_rdy |=> !reply_rdy)
		else $error("byte returned on pass");
	mbox_zero_a: assert property (st_exec && mbox_zero |=> invalid && $stable(mbox_count) && $stable(mbox_ext))
		else $error("zero mailbox count accepted");
	mbox_mode_a: assert property (st_exec && opcode == OP_MBOX24 |=> !mbox_ext) else $error("still 32-bit");

	echo_c: cover property (st_reply && opcode == OP_ECHO && rd_data);
	diag_fail_c: cover property (diag_end && diag_bad);
	dma_c: cover property (dma_req && dma_done && dma_to_host);
	mbox32_c: cover property (st_exec && opcode == OP_MBOX32 && !mbox_zero);
endmodule // sha_cmd
`default_nettype wire

// File: sha_dma_model.sv
`default_nettype none
module sha_dma_model (
	input wire logic core_clk,
	input wire logic dma_req,
	input wire logic [3:0] delay,
	input wire logic fail,
	output logic dma_done,
	output logic dma_ok
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt;
	logic busy;
	// Outside the done pulse the ok line shows the opposite, so a stale sample is caught
	assign dma_ok = dma_done ? !fail : fail;
	initial begin
		cnt = 4'h0;
		busy = 1'b0;
		dma_done = 1'b0;
	end
	always @(posedge core_clk) begin
		dma_done <= 1'b0;
		if (dma_req && !busy && !dma_done) begin
			busy <= 1'b1;
			cnt <= delay;
		end else if (busy) begin
			if (cnt == 4'h0) begin
				dma_done <= 1'b1;
				busy <= 1'b0;
			end else begin
				cnt <= cnt - 4'h1;
			end
		end
	end
endmodule // sha_dma_model
`default_nettype wire

// File: sha_cmd_tb_top.sv
`default_nettype none
module sha_cmd_tb_top;
	import sha_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0, resetn = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
	logic [2:0] bus_addr = 3'h0, own_id = 3'h7;
	logic [7:0] bus_wdata = 8'h00, bus_rdata, tgt_present = 8'hbf, sync_agreed = 8'h55, diag_fail_count = 8'h00;
	logic [23:0] sync_period = 24'hfac688, dma_addr;
	logic [31:0] sync_offset = 32'h9abcdef1, mbox_base;
	logic cfg_sync_neg = 1'b1, cfg_parity = 1'b0, dma_req, dma_to_host, dma_done, dma_ok, adapter_hard_reset, mbox_ext;
	logic [6:0] dma_len;
	logic [7:0] disconnect_mask, busy_retry_mask, mbox_count, b;
	logic [7:0] rep [0:16];
	logic [3:0] dly = 4'h0;
	logic fail = 1'b0;
	int failures = 0, tests_run = 0, hr_cnt = 0, k;
	logic [7:0] ops [0:3] = '{OP_WR_FIFO, OP_WR_RAM, OP_RD_RAM, OP_RD_FIFO};

	sha_cmd #(.DIAG_LEN(8)) DUT (
		.core_clk(core_clk),
		.resetn(resetn),
		.bus_addr(bus_addr),
		.bus_wdata(bus_wdata),
		.bus_wr(bus_wr),
		.bus_rd(bus_rd),
		.bus_rdata(bus_rdata),
		.tgt_present(tgt_present),
		.own_id(own_id),
		.sync_agreed(sync_agreed),
		.sync_period(sync_period),
		.sync_offset(sync_offset),
		.cfg_sync_neg(cfg_sync_neg),
		.cfg_parity(cfg_parity),
		.diag_fail_count(diag_fail_count),
		.dma_req(dma_req),
		.dma_to_host(dma_to_host),
		.dma_addr(dma_addr),
		.dma_len(dma_len),
		.dma_done(dma_done),
		.dma_ok(dma_ok),
		.adapter_hard_reset(adapter_hard_reset),
		.disconnect_mask(disconnect_mask),
		.busy_retry_mask(busy_retry_mask),
		.mbox_count(mbox_count),
		.mbox_base(mbox_base),
		.mbox_ext(mbox_ext)
	);
	sha_dma_model far_end (.core_clk(core_clk), .dma_req(dma_req), .delay(dly), .fail(fail),
		.dma_done(dma_done), .dma_ok(dma_ok));

	always #25 core_clk = ~core_clk;
	always @(posedge core_clk) if (adapter_hard_reset === 1'b1) hr_cnt++;

	task conclude();
		if (failures == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge core_clk);
		bus_wr <= 1'b0;
	endtask
	task rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge core_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge core_clk);
		bus_rd <= 1'b0;
		#1 d = bus_rdata;
	endtask
	task wait_bit(input logic [2:0] a, input int n, input logic v);
		logic [7:0] d;
		int i;
		d = ~{8{v}};
		for (i = 0; i < 60 && d[n] !== v; i++) rd(a, d);
		chk("polled bit", d[n], v);
	endtask
	task finish_cmd();
		wait_bit(REG_INTR, IR_COMPLETE, 1'b1);
		wr(REG_INTR, 8'hff);
		wait_bit(REG_STAT, ST_IDLE_RDY, 1'b1);
	endtask
	task get(output logic [7:0] d);
		wait_bit(REG_STAT, ST_REPLY_RDY, 1'b1);
		rd(REG_DATA, d);
	endtask
	task put3(input logic [7:0] a, input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
		wr(REG_CMD, a);
		wr(REG_CMD, b1);
		wr(REG_CMD, b2);
		wr(REG_CMD, b3);
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		conclude();
	end

	initial begin
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge core_clk);
		rd(3'h5, b);
		chk("unmapped", b, 8'h00);
		// Echo: complete must wait for the host read
		wr(REG_CMD, OP_ECHO);
		wr(REG_CMD, 8'h5a);
		get(b);
		chk("echo data", b, 8'h5a);
		rd(REG_INTR, b);
		rd(REG_INTR, b);
		chk("echo complete", b[IR_COMPLETE], 1'b1);
		finish_cmd();
		put3(OP_OPTIONS, 8'h02, 8'ha5, 8'h3c);
		finish_cmd();
		chk("disc mask", disconnect_mask, 8'ha5);
		chk("retry mask", busy_retry_mask, 8'h3c);
		wr(REG_CMD, OP_INQ_SETUP);
		wr(REG_CMD, INQ_BYTES);
		for (k = 0; k < 17; k++) get(rep[k]);
		finish_cmd();
		chk("mbox count byte", rep[4], 8'h00);
		chk("setup byte 0", rep[0], {6'h00, cfg_parity, cfg_sync_neg});
		for (k = 0; k < 8; k++) chk("sync byte", rep[8+k], (tgt_present[k] && k != own_id) ?
			{sync_agreed[k], sync_period[3*k+:3], sync_offset[4*k+:4]} : 8'h00);
		chk("mask echo", rep[16], 8'ha5);
		wr(REG_CMD, OP_INQ_SETUP);
		wr(REG_CMD, 8'h02);
		get(b);
		get(b);
		finish_cmd();
		rd(REG_STAT, b);
		chk("short reply", b[ST_REPLY_RDY], 1'b0);
		for (int i = 0; i < 4; i++) begin
			dly <= 4'(3 * i);
			put3(ops[i], 8'h12, 8'h34, 8'(8'h50 + i));
			for (k = 0; k < 20 && dma_req !== 1'b1; k++) @(posedge core_clk);
			chk("dma addr", dma_addr, {16'h1234, 8'(8'h50 + i)});
			chk("dma len", dma_len, (i == 0 || i == 3) ? FIFO_LEN : RAM_LEN);
			chk("dma dir", dma_to_host, i >= 2);
			finish_cmd();
			rd(REG_STAT, b);
			chk("dma ok", b[ST_INVALID], 1'b0);
		end
		fail <= 1'b1;
		put3(OP_RD_RAM, 8'h00, 8'h00, 8'h40);
		finish_cmd();
		rd(REG_STAT, b);
		chk("dma fail", b[ST_INVALID], 1'b1);
		fail <= 1'b0;
		put3(OP_MBOX32, 8'h04, 8'h78, 8'h56);
		wr(REG_CMD, 8'h34);
		wr(REG_CMD, 8'h12);
		finish_cmd();
		chk("mbox base", mbox_base, 32'h12345678);
		chk("mbox count", mbox_count, 8'h04);
		chk("ext mode", mbox_ext, 1'b1);
		put3(OP_MBOX32, 8'h00, 8'h11, 8'h22);
		wr(REG_CMD, 8'h33);
		wr(REG_CMD, 8'h44);
		finish_cmd();
		rd(REG_STAT, b);
		chk("zero count", {b[ST_INVALID], mbox_base, mbox_count}, {1'b1, 32'h12345678, 8'h04});
		put3(OP_MBOX24, 8'h02, 8'h0a, 8'h0b);
		wr(REG_CMD, 8'h0c);
		finish_cmd();
		chk("mode 24", {mbox_ext, mbox_count}, {1'b0, 8'h02});
		wr(REG_CMD, OP_INQ_EXT);
		wr(REG_CMD, EXT_BYTES);
		for (k = 0; k < 4; k++) get(rep[k]);
		finish_cmd();
		chk("ext reply", {rep[0], rep[1], rep[2], rep[3]}, 32'h45008000);
		wr(REG_CMD, OP_INQ_EXT);
		wr(REG_CMD, 8'h00);
		finish_cmd();
		rd(REG_STAT, b);
		chk("empty reply", b[ST_REPLY_RDY], 1'b0);
		diag_fail_count <= 8'h03;
		wr(REG_CMD, OP_DIAG);
		rd(REG_STAT, b);
		chk("test running", b[ST_TEST_RUN], 1'b1);
		chk("hard reset", {hr_cnt[7:0], disconnect_mask, mbox_count}, {8'h01, 16'h0000});
		wait_bit(REG_STAT, ST_TEST_RUN, 1'b0);
		rd(REG_STAT, b);
		chk("diag status", {b[ST_IDLE_RDY], b[ST_TEST_FAIL], b[ST_REPLY_RDY]}, 3'b111);
		rd(REG_INTR, b);
		chk("diag intr", b, 8'h84);
		rd(REG_DATA, b);
		chk("fail count", b, 8'h03);
		wr(REG_INTR, 8'hff);
		diag_fail_count <= 8'h00;
		wr(REG_CMD, OP_DIAG);
		wait_bit(REG_STAT, ST_TEST_RUN, 1'b0);
		rd(REG_STAT, b);
		chk("diag pass", {b[ST_IDLE_RDY], b[ST_TEST_FAIL], b[ST_REPLY_RDY]}, 3'b100);
		conclude();
	end
endmodule // sha_cmd_tb_top
`default_nettype wire
